/* rtl/tfica_bank.sv */
// five-channel timer status flags, interrupt enables and register bank
`timescale 1ns/1ps
`default_nettype none
module tfica_bank #(
  parameter int NUM_CH = tfica_pkg::NUM_CH,
  parameter int DMA_CH = tfica_pkg::DMA_CH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic standby,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic busWord,
  input wire logic [7:0] busAddr,
  input wire logic [15:0] busWdata,
  output logic [15:0] busRdata,
  output logic busAck,
  output logic busBusy,
  input wire tfica_pkg::tfica_event_t evt [NUM_CH],
  output tfica_pkg::tfica_irq_t irq [NUM_CH]
);

  tfica_pkg::tfica_acc_t acc;
  logic [15:0] rdWord;
  logic [15:0] chanRd [NUM_CH];
  logic [tfica_pkg::CH_SEL_W-1:0] chanSel;
  logic [3:0] offs;
  logic mapped;

  // bus sequencing and read data registering
  tfica_bus_seq u_seq (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .busReq(busReq),
    .busWrite(busWrite),
    .busWord(busWord),
    .busAddr(busAddr),
    .busWdata(busWdata),
    .rdWord(rdWord),
    .acc(acc),
    .busRdata(busRdata),
    .busAck(busAck),
    .busBusy(busBusy)
  );

  // address decode; the read path follows the address before the access is issued
  logic [7:0] rdAddr;
  assign rdAddr = busBusy ? acc.addr : (busWord ? {busAddr[7:1], 1'b0} : busAddr);
  assign chanSel = rdAddr[tfica_pkg::CH_SEL_LSB +: tfica_pkg::CH_SEL_W];
  assign offs = rdAddr[3:0];
  assign mapped = !rdAddr[7] && (int'(chanSel) < NUM_CH) && (offs <= tfica_pkg::OFF_WIDE_LAST);

  // read mux across channels, unmapped space reads zero
  always_comb
  begin
    rdWord = '0;
    if (mapped)
    begin
      rdWord = chanRd[chanSel];
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      logic [7:0] ctrl_q, ctrl_d;
      logic [7:0] ioctl_q, ioctl_d;
      logic [tfica_pkg::FLAG_W-1:0] irqEn_q, irqEn_d;
      logic [tfica_pkg::FLAG_W-1:0] flags_q, flags_d;
      logic [tfica_pkg::FLAG_W-1:0] armed_q, armed_d;
      logic [15:0] wide_q [tfica_pkg::WIDE_CNT];
      logic [15:0] wide_d [tfica_pkg::WIDE_CNT];
      logic hit;
      logic [3:0] aOffs;
      logic [2:0] wIdx;
      logic [2:0] rIdx;
      logic capA;
      logic capB;
      logic [tfica_pkg::FLAG_W-1:0] setF;
      logic [tfica_pkg::FLAG_W-1:0] clrF;

      assign hit = (acc.addr[7:tfica_pkg::CH_SEL_LSB] == 4'(ch)) && !acc.addr[7];
      assign aOffs = acc.addr[3:0];
      assign wIdx = 3'((aOffs - tfica_pkg::OFF_WIDE_FIRST) >> 1);
      assign rIdx = 3'((offs - tfica_pkg::OFF_WIDE_FIRST) >> 1);
      assign capA = ioctl_q[tfica_pkg::IO_A_CAP_BIT];
      assign capB = ioctl_q[tfica_pkg::IO_B_CAP_BIT];

      // set conditions for the three flags
      always_comb
      begin
        setF = '0;
        setF[tfica_pkg::BIT_A] = (evt[ch].countStep && !capA
          && wide_q[tfica_pkg::WIDE_COUNTER] == wide_q[tfica_pkg::WIDE_GRA])
          || (evt[ch].captA && capA);
        setF[tfica_pkg::BIT_B] = (evt[ch].countStep && !capB
          && wide_q[tfica_pkg::WIDE_COUNTER] == wide_q[tfica_pkg::WIDE_GRB])
          || (evt[ch].captB && capB);
        setF[tfica_pkg::BIT_WRAP] = evt[ch].countStep && (
          (wide_q[tfica_pkg::WIDE_COUNTER] == tfica_pkg::COUNT_MAX
            && evt[ch].newCount == tfica_pkg::COUNT_MIN)
          || (wide_q[tfica_pkg::WIDE_COUNTER] == tfica_pkg::COUNT_MIN
            && evt[ch].newCount == tfica_pkg::COUNT_MAX));
      end

      // next values of the channel registers
      always_comb
      begin
        ctrl_d = ctrl_q;
        ioctl_d = ioctl_q;
        irqEn_d = irqEn_q;
        wide_d = wide_q;
        clrF = '0;
        armed_d = armed_q;
        // datapath loads: counter step and captures
        if (evt[ch].countStep)
        begin
          wide_d[tfica_pkg::WIDE_COUNTER] = evt[ch].newCount;
        end
        if (evt[ch].captA && capA)
        begin
          wide_d[tfica_pkg::WIDE_GRA] = wide_q[tfica_pkg::WIDE_COUNTER];
        end
        if (evt[ch].captB && capB)
        begin
          wide_d[tfica_pkg::WIDE_GRB] = wide_q[tfica_pkg::WIDE_COUNTER];
        end
        // reading status arms every flag seen as one
        if (hit && acc.rd && aOffs == tfica_pkg::OFF_STATUS)
        begin
          armed_d = armed_q | flags_q;
        end
        // cpu writes win over datapath loads
        if (hit && acc.wr)
        begin
          case (aOffs)
            tfica_pkg::OFF_CTRL: ctrl_d = acc.wdata[7:0];
            tfica_pkg::OFF_IOCTL: ioctl_d = acc.wdata[7:0] | tfica_pkg::IOCTL_RSVD;
            tfica_pkg::OFF_IRQEN: irqEn_d = acc.wdata[tfica_pkg::FLAG_W-1:0];
            tfica_pkg::OFF_STATUS:
            begin
              clrF = armed_q & ~acc.wdata[tfica_pkg::FLAG_W-1:0];
              armed_d = '0;
            end
            default:
            begin
              if (aOffs >= tfica_pkg::OFF_WIDE_FIRST && aOffs <= tfica_pkg::OFF_WIDE_LAST)
              begin
                if (acc.wide)
                begin
                  wide_d[wIdx] = acc.wdata;
                end
                else if (!aOffs[0])
                begin
                  wide_d[wIdx][15:8] = acc.wdata[7:0];
                end
                else
                begin
                  wide_d[wIdx][7:0] = acc.wdata[7:0];
                end
              end
            end
          endcase
        end
        // dma start clears flag a in the lower channels only
        if (ch < DMA_CH && evt[ch].dmaStartA)
        begin
          clrF[tfica_pkg::BIT_A] = 1'b1;
        end
        // a set arriving with a clear wins
        flags_d = (flags_q & ~clrF) | setF;
        armed_d = armed_d & flags_d;
      end

      // channel registers, reinitialised by reset and by standby
      always_ff @(posedge sys_clk)
      begin
        if (!rst_b || standby)
        begin
          ctrl_q <= tfica_pkg::CTRL_RESET;
          ioctl_q <= tfica_pkg::IOCTL_RESET;
          irqEn_q <= tfica_pkg::IRQEN_RESET[tfica_pkg::FLAG_W-1:0];
          flags_q <= tfica_pkg::STATUS_RESET[tfica_pkg::FLAG_W-1:0];
          armed_q <= '0;
          for (int i = 0; i < tfica_pkg::WIDE_CNT; i++)
          begin
            wide_q[i] <= tfica_pkg::WIDE_RESET;
          end
        end
        else
        begin
          ctrl_q <= ctrl_d;
          ioctl_q <= ioctl_d;
          irqEn_q <= irqEn_d;
          flags_q <= flags_d;
          armed_q <= armed_d;
          wide_q <= wide_d;
        end
      end

      // read data of this channel, byte reads in the low lane
      always_comb
      begin
        chanRd[ch] = '0;
        case (offs)
          tfica_pkg::OFF_CTRL: chanRd[ch] = {tfica_pkg::BYTE_ZERO, ctrl_q};
          tfica_pkg::OFF_IOCTL: chanRd[ch] = {tfica_pkg::BYTE_ZERO, ioctl_q};
          tfica_pkg::OFF_IRQEN: chanRd[ch] = {tfica_pkg::BYTE_ZERO,
            tfica_pkg::IRQEN_RESET | 8'(irqEn_q)};
          tfica_pkg::OFF_STATUS: chanRd[ch] = {tfica_pkg::BYTE_ZERO,
            tfica_pkg::FLAG_RSVD | 8'(flags_q)};
          default:
          begin
            if (busWord && !busBusy)
            begin
              chanRd[ch] = wide_q[rIdx];
            end
            else
            begin
              chanRd[ch] = {tfica_pkg::BYTE_ZERO,
                offs[0] ? wide_q[rIdx][7:0] : wide_q[rIdx][15:8]};
            end
          end
        endcase
      end

      // requests are flag and enable, level while both hold
      assign irq[ch].wrapReq = flags_q[tfica_pkg::BIT_WRAP]
        && irqEn_q[tfica_pkg::BIT_WRAP];
      assign irq[ch].reqB = flags_q[tfica_pkg::BIT_B] && irqEn_q[tfica_pkg::BIT_B];
      assign irq[ch].reqA = flags_q[tfica_pkg::BIT_A] && irqEn_q[tfica_pkg::BIT_A];
    end
  endgenerate

endmodule // tfica_bank
`default_nettype wire

/* rtl/tfica_bus_seq.sv */
// cpu access sequencer: word or byte on wide registers, byte or byte pair (for a word) on narrow ones
`timescale 1ns/1ps
`default_nettype none
module tfica_bus_seq (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic busWord,
  input wire logic [7:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic [15:0] rdWord,
  output tfica_pkg::tfica_acc_t acc,
  output logic [15:0] busRdata,
  output logic busAck,
  output logic busBusy
);

  tfica_pkg::tfica_state_t state_q, state_d;
  logic [7:0] addrHold_q, addrHold_d;
  logic [7:0] dataHold_q, dataHold_d;
  logic [7:0] rdHi_q, rdHi_d;
  logic writeHold_q, writeHold_d;
  logic [15:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic narrow;

  // narrow registers sit below the first wide offset
  assign narrow = busAddr[3:0] < tfica_pkg::OFF_WIDE_FIRST;
  assign busBusy = state_q == tfica_pkg::ST_SECOND;
  assign busRdata = rdata_q;
  assign busAck = ack_q;

  // next-state, access issue and read assembly
  always_comb
  begin
    state_d = state_q;
    addrHold_d = addrHold_q;
    dataHold_d = dataHold_q;
    rdHi_d = rdHi_q;
    writeHold_d = writeHold_q;
    rdata_d = rdata_q;
    ack_d = 1'b0;
    acc = '0;
    case (state_q)
      tfica_pkg::ST_IDLE:
      begin
        if (busReq && busWord && narrow)
        begin
          // word on narrow register: upper byte now, lower byte next cycle
          acc.rd = !busWrite;
          acc.wr = busWrite;
          acc.addr = {busAddr[7:1], 1'b0};
          acc.wdata = {tfica_pkg::BYTE_ZERO, busWdata[15:8]};
          addrHold_d = {busAddr[7:1], 1'b1};
          dataHold_d = busWdata[7:0];
          writeHold_d = busWrite;
          rdHi_d = rdWord[7:0];
          state_d = tfica_pkg::ST_SECOND;
        end
        else if (busReq)
        begin
          // single access: whole word or one byte
          acc.rd = !busWrite;
          acc.wr = busWrite;
          acc.wide = busWord;
          acc.addr = busWord ? {busAddr[7:1], 1'b0} : busAddr;
          acc.wdata = busWord ? busWdata : {tfica_pkg::BYTE_ZERO, busWdata[7:0]};
          rdata_d = busWord ? rdWord : {tfica_pkg::BYTE_ZERO, rdWord[7:0]};
          ack_d = 1'b1;
        end
      end
      tfica_pkg::ST_SECOND:
      begin
        acc.rd = !writeHold_q;
        acc.wr = writeHold_q;
        acc.addr = addrHold_q;
        acc.wdata = {tfica_pkg::BYTE_ZERO, dataHold_q};
        rdata_d = {rdHi_q, rdWord[7:0]};
        ack_d = 1'b1;
        state_d = tfica_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = tfica_pkg::ST_IDLE;
      end
    endcase
  end

  // registers of the sequencer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_q <= tfica_pkg::ST_IDLE;
      addrHold_q <= '0;
      dataHold_q <= '0;
      rdHi_q <= '0;
      writeHold_q <= 1'b0;
      rdata_q <= '0;
      ack_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      addrHold_q <= addrHold_d;
      dataHold_q <= dataHold_d;
      rdHi_q <= rdHi_d;
      writeHold_q <= writeHold_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
    end
  end

endmodule // tfica_bus_seq
`default_nettype wire

/* rtl/tfica_pkg.sv */
// shared constants and types for the timer flag, interrupt and cpu access bank
package tfica_pkg;

  // channel layout
  localparam int NUM_CH = 5;
  localparam int DMA_CH = 4;
  localparam int ADDR_W = 8;
  localparam int CH_SEL_LSB = 4;
  localparam int CH_SEL_W = 3;
  localparam int WIDE_CNT = 5;

  // per-channel byte offsets (channel stride is sixteen bytes)
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_IOCTL = 4'h1;
  localparam logic [3:0] OFF_IRQEN = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h3;
  localparam logic [3:0] OFF_WIDE_FIRST = 4'h4;
  localparam logic [3:0] OFF_WIDE_LAST = 4'hd;

  // index of each 16-bit register inside the wide bank
  localparam int WIDE_COUNTER = 0;
  localparam int WIDE_GRA = 1;
  localparam int WIDE_GRB = 2;
  localparam int WIDE_BRA = 3;
  localparam int WIDE_BRB = 4;

  // flag and enable bit positions (same in status and enable registers)
  localparam int BIT_A = 0;
  localparam int BIT_B = 1;
  localparam int BIT_WRAP = 2;
  localparam int FLAG_W = 3;

  // i/o control: top bit of each 3-bit field selects input capture
  localparam int IO_A_CAP_BIT = 2;
  localparam int IO_B_CAP_BIT = 6;

  // reset values and reserved masks
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] IOCTL_RESET = 8'h88;
  localparam logic [7:0] IOCTL_RSVD = 8'h88;
  localparam logic [7:0] IRQEN_RESET = 8'hf8;
  localparam logic [7:0] STATUS_RESET = 8'hf8;
  localparam logic [7:0] FLAG_RSVD = 8'hf8;
  localparam logic [15:0] WIDE_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_MIN = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // events from the counter datapath for one channel
  typedef struct packed {
    logic countStep;
    logic [15:0] newCount;
    logic captA;
    logic captB;
    logic dmaStartA;
  } tfica_event_t;

  // interrupt requests of one channel
  typedef struct packed {
    logic wrapReq;
    logic reqB;
    logic reqA;
  } tfica_irq_t;

  // one internal register access, byte data in the low lane
  typedef struct packed {
    logic rd;
    logic wr;
    logic wide;
    logic [7:0] addr;
    logic [15:0] wdata;
  } tfica_acc_t;

  typedef enum logic {ST_IDLE, ST_SECOND} tfica_state_t;

endpackage

/* tb/tfica_bank_checker.sv */
// bus timing and interrupt request checks bound to the register bank
`timescale 1ns/1ps
`default_nettype none
module tfica_bank_checker #(
  parameter int NUM_CH = tfica_pkg::NUM_CH,
  parameter int DMA_CH = tfica_pkg::DMA_CH
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic standby,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic busWord,
  input wire logic [7:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic [15:0] busRdata,
  input wire logic busAck,
  input wire logic busBusy,
  input wire tfica_pkg::tfica_event_t evt [NUM_CH],
  input wire tfica_pkg::tfica_irq_t irq [NUM_CH]
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // taken request, mapped target, and causes that may raise request a
  logic take;
  logic mapped;
  logic causeA;
  assign take = busReq && !busBusy;
  assign mapped = !busAddr[7] && busAddr[6:4] < 3'(NUM_CH);
  assign causeA = evt[0].countStep || evt[0].captA;

  a_single_ack: assert property (take && mapped && !(busWord && busAddr[3:2] == 2'b00)
    |=> busAck) else $error("single access not acknowledged next cycle");
  a_split_word: assert property (take && mapped && busWord && busAddr[3:2] == 2'b00
    |=> busBusy ##1 (busAck && !busBusy)) else $error("word to byte pair not split");
  a_busy_once: assert property (busBusy |=> !busBusy)
    else $error("busy held beyond one cycle");
  a_no_spurious: assert property (!busReq && !busBusy |=> !busAck)
    else $error("acknowledge without request");
  a_rdata_hold: assert property (!busAck |-> $stable(busRdata))
    else $error("read data moved without acknowledge");
  a_reset_quiet: assert property ($rose(rst_b) |-> !busAck && !busBusy
    && irq[0] == 3'b000 && busRdata == 16'h0000) else $error("outputs not idle after reset");
  a_standby_quiet: assert property (standby |=> irq[0] == 3'b000 && irq[NUM_CH - 1] == 3'b000)
    else $error("request survived standby");
  a_dma_clear: assert property (evt[0].dmaStartA && !causeA && !standby |=> !irq[0].reqA)
    else $error("dma start left flag a set");
  a_dma_keep: assert property (irq[DMA_CH].reqA && evt[DMA_CH].dmaStartA && !take && !busBusy
    && !standby && !$past(take) |=> irq[DMA_CH].reqA) else $error("dma start cleared flag a");
  a_irq_cause: assert property ($rose(irq[0].reqA) |-> $past(causeA) || $past(take)
    || $past(take, 2) || $past(busBusy)) else $error("request a rose without cause");
endmodule // tfica_bank_checker

bind tfica_bank tfica_bank_checker #(
  .NUM_CH(NUM_CH),
  .DMA_CH(DMA_CH)
) tfica_bank_checker_i (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .standby(standby),
  .busReq(busReq),
  .busWrite(busWrite),
  .busWord(busWord),
  .busAddr(busAddr),
  .busWdata(busWdata),
  .busRdata(busRdata),
  .busAck(busAck),
  .busBusy(busBusy),
  .evt(evt),
  .irq(irq)
);
`default_nettype wire

/* tb/tfica_bank_tb.sv */
// self-checking bench for the timer flag and register bank
`timescale 1ns/1ps
`default_nettype none
module tfica_bank_tb;
  logic sys_clk;
  logic rst_b;
  logic standby;
  logic busReq;
  logic busWrite;
  logic busWord;
  logic [7:0] busAddr;
  logic [15:0] busWdata;
  logic [15:0] busRdata;
  logic busAck;
  logic busBusy;
  tfica_pkg::tfica_event_t evt [tfica_pkg::NUM_CH];
  tfica_pkg::tfica_irq_t irq [tfica_pkg::NUM_CH];
  logic [15:0] q;
  int badCount = 0;
  int comparisons = 0;

  tfica_bank tfica_bank_i (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .standby(standby),
    .busReq(busReq),
    .busWrite(busWrite),
    .busWord(busWord),
    .busAddr(busAddr),
    .busWdata(busWdata),
    .busRdata(busRdata),
    .busAck(busAck),
    .busBusy(busBusy),
    .evt(evt),
    .irq(irq)
  );

  tfica_cpu_model tfica_cpu_model_i (
    .sys_clk(sys_clk),
    .busReq(busReq),
    .busWrite(busWrite),
    .busWord(busWord),
    .busAddr(busAddr),
    .busWdata(busWdata),
    .busRdata(busRdata),
    .busAck(busAck),
    .evt(evt)
  );

  // free-running system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // counts, verdict and end of run
  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // data compare, also used for request levels
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic wd, input logic [15:0] e);
    tfica_cpu_model_i.access(1'b0, wd, a, 16'h0000, q);
    chk(q, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic wd, input logic [15:0] d);
    tfica_cpu_model_i.access(1'b1, wd, a, d, q);
  endtask

  task automatic chkIrq(input int ch, input logic [2:0] e);
    chk({13'h0000, irq[ch]}, {13'h0000, e});
  endtask

  // compare on one general register, capture on the other, then clearing
  task automatic flags(input int ch, input logic [7:0] io);
    logic [7:0] b;
    b = 8'(ch * 16);
    wr(b + 8'h02, 1'b1, 16'h07f8);
    rd(b + 8'h02, 1'b0, 16'h00ff);
    wr(b + 8'h01, 1'b0, {8'h00, io});
    wr(b + 8'h06, 1'b1, 16'h0010);
    wr(b + 8'h08, 1'b1, 16'h0010);
    tfica_cpu_model_i.pulse(ch, 4'h1, 16'h0010);
    tfica_cpu_model_i.pulse(ch, 4'h1, 16'h0011);
    tfica_cpu_model_i.pulse(ch, io[6] ? 4'h4 : 4'h2, 16'h0011);
    chkIrq(ch, 3'b011);
    rd(b + (io[6] ? 8'h08 : 8'h06), 1'b1, 16'h0011);
    wr(b + 8'h03, 1'b0, 16'h00f8);
    rd(b + 8'h03, 1'b0, 16'h00fb);
    wr(b + 8'h03, 1'b0, 16'h00f8);
    rd(b + 8'h03, 1'b0, 16'h00f8);
    chkIrq(ch, 3'b000);
  endtask

  // watchdog well beyond the expected run length
  initial
  begin
    #200000;
    badCount++;
    $display("watchdog expired");
    giveVerdict();
  end

  // main sequence
  initial
  begin
    rst_b = 1'b0;
    standby = 1'b0;
    repeat (16) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    for (int c = 0; c < 5; c++)
    begin
      rd(8'(c * 16 + 2), 1'b0, 16'h00f8);
      rd(8'(c * 16 + 3), 1'b0, 16'h00f8);
    end
    wr(8'h00, 1'b0, 16'h005a);
    rd(8'h00, 1'b1, 16'h5a88);
    rd(8'h80, 1'b0, 16'h0000);
    wr(8'h02, 1'b0, 16'h00ff);
    rd(8'h02, 1'b0, 16'h00ff);
    wr(8'h02, 1'b0, 16'h0000);
    rd(8'h02, 1'b0, 16'h00f8);
    wr(8'h16, 1'b1, 16'h1234);
    wr(8'h17, 1'b0, 16'h00ab);
    rd(8'h16, 1'b1, 16'h12ab);
    rd(8'h16, 1'b0, 16'h0012);
    $display("test reset and access done");
    flags(0, 8'h40);
    flags(2, 8'h04);
    $display("test flags done");
    for (int c = 0; c < 5; c += 4)
    begin
      wr(8'(c * 16 + 2), 1'b0, 16'h0001);
      wr(8'(c * 16 + 1), 1'b0, 16'h0004);
      tfica_cpu_model_i.pulse(c, 4'h2, 16'h0000);
      chkIrq(c, 3'b001);
      tfica_cpu_model_i.pulse(c, 4'h8, 16'h0000);
      chkIrq(c, c < tfica_pkg::DMA_CH ? 3'b000 : 3'b001);
    end
    $display("test dma done");
    for (int c = 1; c < 4; c += 2)
    begin
      wr(8'(c * 16 + 2), 1'b0, 16'h0004);
      // capture on both general registers so the counter walk cannot raise a match
      wr(8'(c * 16 + 1), 1'b0, 16'h0044);
      tfica_cpu_model_i.pulse(c, 4'h1, 16'h8000);
      tfica_cpu_model_i.pulse(c, 4'h1, c == 1 ? 16'hffff : 16'h0000);
      chkIrq(c, 3'b000);
      tfica_cpu_model_i.pulse(c, 4'h1, c == 1 ? 16'h0000 : 16'hffff);
      chkIrq(c, 3'b100);
      wr(8'(c * 16 + 2), 1'b0, 16'h0000);
      chkIrq(c, 3'b000);
      rd(8'(c * 16 + 3), 1'b0, 16'h00fc);
    end
    $display("test wrap done");
    tfica_cpu_model_i.pulse(4, 4'h2, 16'h0000);
    chkIrq(4, 3'b001);
    @(posedge sys_clk);
    #1;
    standby = 1'b1;
    @(posedge sys_clk);
    #1;
    standby = 1'b0;
    chkIrq(4, 3'b000);
    rd(8'h42, 1'b0, 16'h00f8);
    rd(8'h43, 1'b0, 16'h00f8);
    $display("test standby done");
    giveVerdict();
  end
endmodule // tfica_bank_tb
`default_nettype wire

/* tb/tfica_cpu_model.sv */
// cpu bus master and counter event source facing the bank
`timescale 1ns/1ps
`default_nettype none
module tfica_cpu_model #(
  parameter int NUM_CH = tfica_pkg::NUM_CH
) (
  input wire logic sys_clk,
  output var logic busReq,
  output var logic busWrite,
  output var logic busWord,
  output var logic [7:0] busAddr,
  output var logic [15:0] busWdata,
  input wire logic [15:0] busRdata,
  input wire logic busAck,
  output var tfica_pkg::tfica_event_t evt [NUM_CH]
);
  // idle bus and quiet events from time zero
  initial
  begin
    busReq = 1'b0;
    busWrite = 1'b0;
    busWord = 1'b0;
    busAddr = 8'h80;
    busWdata = 16'h0000;
    for (int i = 0; i < NUM_CH; i++)
      evt[i] = '0;
  end

  // request pulse, qualifiers held until acknowledge, data then scrambled
  task automatic access(input logic wr, input logic wd, input logic [7:0] a,
    input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge sys_clk);
    #1;
    busReq = 1'b1;
    busWrite = wr;
    busWord = wd;
    busAddr = a;
    busWdata = d;
    @(posedge sys_clk);
    #1;
    busReq = 1'b0;
    n = 0;
    while (busAck !== 1'b1 && n < 4)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    q = (busAck === 1'b1) ? busRdata : 16'hxxxx;
    busAddr = ~a;
    busWdata = ~d;
  endtask

  // one-cycle event, kind bits are dma, capture b, capture a, step
  task automatic pulse(input int ch, input logic [3:0] k, input logic [15:0] c);
    @(posedge sys_clk);
    #1;
    evt[ch] = {k[0], c, k[1], k[2], k[3]};
    @(posedge sys_clk);
    #1;
    evt[ch] = {1'b0, ~c, 3'b000};
  endtask
endmodule // tfica_cpu_model
`default_nettype wire
